/* File: talk_mode_responder.sv */
// talk mode responder: mode state, response words, error latch
// assumes avalon-mm master holding requests until waitrequest is low
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
module talk_mode_responder (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [4:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  input  wire logic [11:0] err_evt_i,
  input  wire logic        meas_err_i,
  input  wire logic [31:0] meas_float_i,
  input  wire logic [31:0] meas_fixed_i,
  input  wire logic [2:0]  meas_unit_i,
  input  wire logic [7:0]  param_num_i,
  input  wire logic [31:0] param_val_i,
  output logic [3:0]       active_mode_o,
  output logic [6:0]       err_code_o,
  output logic             talk_done_o,
  output logic             freq_reset_o
);
  typedef struct packed {
    logic [3:0]  sel;
    talk_pkg::tm_state_t st;
    logic [1:0]  ld_kind;
    logic [2:0]  ld_idx;
    logic [2:0]  rd_idx;
    logic [talk_pkg::NKIND-1:0][talk_pkg::NWORD-1:0][15:0] cal;
    logic [talk_pkg::NWORD-1:0][15:0] tbuf;
    logic [1:0]  tkind;
    logic [6:0]  err;
    logic        refused;
    logic        valid;
    logic [31:0] resp0;
    logic [31:0] resp1;
    logic [31:0] resp2;
    logic        wreq;
    logic [3:0]  amode;
    logic [31:0] rdata;
    logic        done;
    logic        frst;
  } state_t;

  state_t q;
  state_t d;

  logic       req;
  logic       ack;
  logic [2:0] widx;
  logic [6:0] new_code;
  logic       new_evt;
  logic [3:0] mode_now;

  assign req  = read_i | write_i;
  assign ack  = req & ~q.wreq;
  assign widx = address_i[4:2];

  // lowest event bit wins among simultaneous events
  always_comb begin
    new_code = talk_pkg::ERR_NONE;
    new_evt  = 1'b0;
    for (int i = talk_pkg::NEVT - 1; i >= 0; i--) begin
      if (err_evt_i[i]) begin
        new_code = talk_pkg::ERR_CODE[i];
        new_evt  = 1'b1;
      end
    end
  end

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.frst = err_evt_i[talk_pkg::EV_FREQ];
    mode_now = (q.st == talk_pkg::TM_ARRAY) ? talk_pkg::MODE_ARRAY : q.sel;
    // wreq low for one cycle: request seen, answer next cycle
    d.wreq = ~(req & q.wreq);
    if (req & q.wreq & read_i) begin
      case (widx)
        talk_pkg::A_MODE:  d.rdata = {24'h0, mode_now, q.sel};
        talk_pkg::A_STAT:  d.rdata = {29'h0, q.refused,
                                      q.st == talk_pkg::TM_ARRAY, q.valid};
        talk_pkg::A_ERR:   d.rdata = {25'h0, q.err};
        talk_pkg::A_RESP0: d.rdata = q.resp0;
        talk_pkg::A_RESP1: d.rdata = q.resp1;
        talk_pkg::A_RESP2: d.rdata = q.resp2;
        talk_pkg::A_ARRAY: d.rdata = {16'h0, q.tbuf[q.rd_idx]};
        default:           d.rdata = 32'h0;
      endcase
    end

    if (ack && read_i && widx == talk_pkg::A_ARRAY) begin
      d.rd_idx = q.rd_idx + 3'h1;
    end

    if (ack && write_i) begin
      case (widx)
        talk_pkg::A_MODE: begin
          if (writedata_i[3:0] < talk_pkg::MODE_ARRAY) begin
            d.sel = writedata_i[3:0];
          end else begin
            d.refused = 1'b1;
          end
        end
        talk_pkg::A_CMD: begin
          if (writedata_i[talk_pkg::C_CLEAR]) begin
            d.st      = talk_pkg::TM_DIRECT;
            d.refused = 1'b0;
          end
          if (writedata_i[talk_pkg::C_LOAD]) begin
            d.ld_kind = writedata_i[talk_pkg::C_KLO +: 2];
            d.ld_idx  = 3'h0;
          end
          if (writedata_i[talk_pkg::C_DUMP] &&
              writedata_i[talk_pkg::C_KLO +: 2] != 2'h3) begin
            d.st    = talk_pkg::TM_ARRAY;
            d.tkind = writedata_i[talk_pkg::C_KLO +: 2];
            d.tbuf  = q.cal[writedata_i[talk_pkg::C_KLO +: 2]];
          end
          if (writedata_i[talk_pkg::C_TALK]) begin
            d.done  = 1'b1;
            d.valid = 1'b1;
            d.resp0 = 32'h0;
            d.resp1 = 32'h0;
            d.resp2 = 32'h0;
            case (mode_now)
              talk_pkg::MODE_FLOAT: begin
                d.resp0 = {31'h0, meas_err_i};
                d.resp1 = meas_float_i;
              end
              talk_pkg::MODE_UNITS: begin
                d.resp0 = {31'h0, meas_err_i};
                d.resp1 = meas_fixed_i;
                d.resp2 = {29'h0, meas_unit_i};
              end
              talk_pkg::MODE_ERROR: begin
                d.resp1 = {25'h0, q.err};
                d.err   = talk_pkg::ERR_NONE;
              end
              talk_pkg::MODE_MSG: begin
                d.valid = 1'b0;
              end
              talk_pkg::MODE_PARAM: begin
                d.resp0 = {24'h0, param_num_i};
                d.resp1 = param_val_i;
              end
              talk_pkg::MODE_ARRAY: begin
                d.resp0  = {30'h0, q.tkind};
                d.resp1  = talk_pkg::NWORD;
                d.rd_idx = 3'h0;
                d.st     = talk_pkg::TM_DIRECT;
              end
              default: begin
                d.resp0 = 32'h0;
              end
            endcase
          end
        end
        talk_pkg::A_ARRAY: begin
          if (q.ld_kind != 2'h3) begin
            d.cal[q.ld_kind][q.ld_idx] = writedata_i[15:0];
            d.ld_idx = q.ld_idx + 3'h1;
          end
        end
        default: begin
          d.refused = q.refused;
        end
      endcase
    end

    // set after clear: an event in the clearing cycle is kept
    if (d.err == talk_pkg::ERR_NONE) begin
      if (ack && write_i && widx == talk_pkg::A_ERR &&
          writedata_i[6:0] != talk_pkg::ERR_NONE) begin
        d.err = writedata_i[6:0];
      end else if (new_evt) begin
        d.err = new_code;
      end
    end

    // active mode kept in a flop so the output is registered
    d.amode = (d.st == talk_pkg::TM_ARRAY) ? talk_pkg::MODE_ARRAY :
                                             d.sel;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q        <= '0;
      q.sel    <= talk_pkg::MODE_RESET;
      q.st     <= talk_pkg::TM_DIRECT;
      q.wreq   <= 1'b1;
      q.amode  <= talk_pkg::MODE_RESET;
      q.err    <= talk_pkg::ERR_NONE;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign readdata_o    = q.rdata;
  assign waitrequest_o = q.wreq;
  assign active_mode_o = q.amode;
  assign err_code_o    = q.err;
  assign talk_done_o   = q.done;
  assign freq_reset_o  = q.frst;
endmodule

/* File: talk_pkg.sv */
// constants, register map and types for the talk mode responder
// assumes a 32-bit avalon-mm slave port with byte addresses
//
// Summary of operation
// - talk modes 0..6 chosen by response_format_select; held until changed
// - array output enters mode 7; direct 7 refused; left after transfer
// - after reset the current talk mode is 0
// - a talk request answers in the current mode with no other command
// - mode 0: error flag then floating point measurement
// - mode 1: error flag, fixed point value and unit code
// - mode 2: zero, measurement error code 0..99, zero
// - a mode 2 report clears the stored error
// - of several errors the earliest one is kept
// - modes 3 and 8 give no error-with-message answer
// - out-of-range numeric entry stores code 1
// - underrange stores code 3, overrange stores code 4
// - autorange below range 0 stores code 5
// - failed zeroing stores code 6
// - frequency out of range stores code 24 and resets frequency
// - calibration off reference level stores code 39
// - calibration before filter full stores code 42
// - offset calibration without full scale stores code 96
// - protection jumper engaged stores 97, uninitialised memory 98
// - code 99 marks the bus interface option as absent
// - three listen arrays: ac linearity, dc and hf calibration data
// - three talk arrays dump the same data on the next talk
// - array output builds a talk buffer sent once at next talk
// - clear ends array talk mode and restores the chosen mode
// - mode 6: active parameter number and value, 0 means none
package talk_pkg;
  localparam logic [2:0] A_MODE   = 3'h0;
  localparam logic [2:0] A_CMD    = 3'h1;
  localparam logic [2:0] A_STAT   = 3'h2;
  localparam logic [2:0] A_ERR    = 3'h3;
  localparam logic [2:0] A_RESP0  = 3'h4;
  localparam logic [2:0] A_RESP1  = 3'h5;
  localparam logic [2:0] A_RESP2  = 3'h6;
  localparam logic [2:0] A_ARRAY  = 3'h7;

  localparam logic [3:0] MODE_FLOAT = 4'h0;
  localparam logic [3:0] MODE_UNITS = 4'h1;
  localparam logic [3:0] MODE_ERROR = 4'h2;
  localparam logic [3:0] MODE_MSG   = 4'h3;
  localparam logic [3:0] MODE_PARAM = 4'h6;
  localparam logic [3:0] MODE_ARRAY = 4'h7;
  localparam logic [3:0] MODE_RESET = 4'h0;

  // command register bits
  localparam int C_TALK  = 0;
  localparam int C_CLEAR = 1;
  localparam int C_DUMP  = 2;
  localparam int C_LOAD  = 3;
  localparam int C_KLO   = 4;

  localparam int NKIND  = 3;
  localparam int NWORD  = 8;
  localparam int NEVT   = 12;
  localparam logic [1:0] KIND_AC = 2'h0;
  localparam logic [1:0] KIND_DC = 2'h1;
  localparam logic [1:0] KIND_HF = 2'h2;

  // event input bit to stored error code
  localparam logic [6:0] ERR_NONE = 7'h00;
  localparam logic [NEVT-1:0][6:0] ERR_CODE = {
    7'h63, 7'h62, 7'h61, 7'h60, 7'h2a, 7'h18,
    7'h27, 7'h06, 7'h05, 7'h04, 7'h03, 7'h01};
  localparam int EV_FREQ = 6;

  typedef enum logic [0:0] {
    TM_DIRECT = 1'b0,
    TM_ARRAY  = 1'b1
  } tm_state_t;
endpackage

/* File: talk_sva.sv */
// port assertions for the talk mode responder
// assumes one clock and a synchronous active-high reset
module talk_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic [4:0]  address_i,
  input wire logic        write_i,
  input wire logic [31:0] writedata_i,
  input wire logic        waitrequest_o,
  input wire logic [11:0] err_evt_i,
  input wire logic [3:0]  active_mode_o,
  input wire logic [6:0]  err_code_o,
  input wire logic        talk_done_o,
  input wire logic        freq_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic acc;
  assign acc = ce_i && write_i && !waitrequest_o;
  property p_rst;
    disable iff (1'b0) $fell(rst_i) |-> active_mode_o == 4'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("mode not 0 after reset");
  property p_keep;
    $changed(err_code_o) |-> $past(err_code_o) == 7'h00 || err_code_o == 7'h00;
  endproperty
  a_keep: assert property (p_keep) else $error("error code overwritten");
  property p_e1;
    ce_i && err_code_o == 7'h00 && err_evt_i[0] &&
      !(acc && address_i[4:2] == 3'h3) |=> err_code_o == 7'h01;
  endproperty
  a_e1: assert property (p_e1) else $error("code 1 not stored");
  property p_e3;
    ce_i && err_code_o == 7'h00 && err_evt_i[1:0] == 2'h2 &&
      !(acc && address_i[4:2] == 3'h3) |=> err_code_o == 7'h03;
  endproperty
  a_e3: assert property (p_e3) else $error("code 3 not stored");
  property p_freq;
    !$past(rst_i) && $past(ce_i) |-> freq_reset_o == $past(err_evt_i[6]);
  endproperty
  a_freq: assert property (p_freq) else $error("frequency reset wrong");
  property p_refuse;
    acc && address_i[4:2] == 3'h0 && writedata_i[3:0] >= 4'h7
      |=> active_mode_o == $past(active_mode_o);
  endproperty
  a_refuse: assert property (p_refuse) else $error("mode 7 taken");
  property p_talk;
    acc && address_i[4:2] == 3'h1 && writedata_i[0] |=> talk_done_o;
  endproperty
  a_talk: assert property (p_talk) else $error("talk not answered");
  property p_clr;
    talk_done_o && $past(active_mode_o) == 4'h2 && $past(err_evt_i) == 12'h000
      |-> err_code_o == 7'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("error not cleared");
  c_arr: cover property (talk_done_o && $past(active_mode_o) == 4'h7);
  c_err: cover property (err_code_o == 7'h63);
  c_mode6: cover property (talk_done_o && $past(active_mode_o) == 4'h6);
endmodule

/* File: bus_master.sv */
// avalon-mm master standing in for the bus controller
// assumes the slave drops waitrequest once per access
module bus_master (
  input  wire logic        clk_i,
  input  wire logic        waitrequest_i,
  input  wire logic [31:0] readdata_i,
  output logic [4:0]       address_o,
  output logic             read_o,
  output logic             write_o,
  output logic [31:0]      writedata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {address_o, read_o, write_o, writedata_o} = '0;
  task automatic xfer(input logic w, input logic [2:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    address_o <= {a, 2'h0};
    writedata_o <= d;
    write_o <= w;
    read_o <= !w;
    do @(posedge clk_i); while (waitrequest_i);
    q = readdata_i;
    write_o <= 1'b0;
    read_o <= 1'b0;
    writedata_o <= ~d;
  endtask
endmodule

/* File: tb.sv */
// self-checking bench for the talk mode responder
// assumes bus_master and talk_sva are compiled first
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, meas_err_i = 1'b0;
  logic [11:0] err_evt_i = 12'h000;
  logic [31:0] meas_float_i = 32'h0, meas_fixed_i = 32'h0, param_val_i = 32'h0;
  logic [7:0]  param_num_i = 8'h00;
  logic [2:0]  meas_unit_i = 3'h0;
  logic [4:0]  address_i;
  logic        read_i, write_i, waitrequest_o;
  logic [31:0] writedata_i, readdata_o, q;
  logic [15:0] s = 16'h1a0d, w [8];
  logic [6:0]  code [12] = '{7'h01, 7'h03, 7'h04, 7'h05, 7'h06, 7'h27,
                             7'h18, 7'h2a, 7'h60, 7'h61, 7'h62, 7'h63};
  int          fail_count = 0, samples_checked = 0, cyc = 0, i, k, m;
  always #5 clk_i = ~clk_i;
  talk_mode_responder dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .err_evt_i(err_evt_i),
    .meas_err_i(meas_err_i), .meas_float_i(meas_float_i),
    .meas_fixed_i(meas_fixed_i), .meas_unit_i(meas_unit_i),
    .param_num_i(param_num_i), .param_val_i(param_val_i),
    .active_mode_o(), .err_code_o(), .talk_done_o(), .freq_reset_o());
  bus_master bm_u (.clk_i(clk_i), .waitrequest_i(waitrequest_o),
    .readdata_i(readdata_o), .address_o(address_i), .read_o(read_i),
    .write_o(write_i), .writedata_o(writedata_i));
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [31:0] resp(input int md, input int ix);
    if (ix == 0) begin
      return (md == 6) ? {24'h0, param_num_i} :
             (md < 2)  ? {31'h0, meas_err_i} : 32'h0;
    end
    if (ix == 1) begin
      return (md == 6) ? param_val_i :
             (md == 0) ? meas_float_i :
             (md == 1) ? meas_fixed_i : 32'h0;
    end
    return (md == 1) ? {29'h0, meas_unit_i} : 32'h0;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    bm_u.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [2:0] a);
    bm_u.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(3'h0); chk(q[3:0], 4'h0);
    rd(3'h1); chk(q, 32'h0);
    for (m = 0; m < 7; m++) begin
      s = nx(s); meas_err_i <= s[0]; meas_float_i <= {s, ~s};
      meas_fixed_i <= {~s, s}; meas_unit_i <= 3'(s[7:0] % 6);
      param_num_i <= s[15:8]; param_val_i <= {s, s};
      wr(3'h0, m); wr(3'h1, 32'h1);
      for (k = 0; k < 3; k++) if (k < 2 || (m != 0 && m != 6)) begin
        rd(3'(4 + k)); chk(q, resp(m, k));
      end
      rd(3'h2);
      chk(q, 32'(m != 3));
    end
    $display("test modes done");
    wr(3'h0, 32'h2);
    for (i = 0; i < 12; i++) begin
      ce_i <= 1'b0; err_evt_i <= 12'h1 << i; repeat (3) @(posedge clk_i);
      ce_i <= 1'b1; repeat (5) @(posedge clk_i);
      err_evt_i <= 12'h1 << ((i + 5) % 12); repeat (8) @(posedge clk_i);
      err_evt_i <= 12'h000;
      rd(3'h3); chk(q, code[i]);
      wr(3'h1, 32'h1); rd(3'h5); chk(q, code[i]);
      rd(3'h3); chk(q, 32'h0);
    end
    for (m = 7; m < 16; m++) begin
      wr(3'h0, m); rd(3'h0); chk(q[3:0], 4'h2);
    end
    rd(3'h2); chk(q[2], 1'b1);
    $display("test errors done");
    for (i = 0; i < 3; i++) begin
      wr(3'h1, 32'h8 | (i << 4));
      for (k = 0; k < 8; k++) begin
        s = nx(s); w[k] = s; wr(3'h7, {16'h0, s});
      end
      wr(3'h1, 32'h4 | (i << 4)); rd(3'h0); chk(q[7:4], 4'h7);
      wr(3'h1, 32'h1); rd(3'h4); chk(q, i);
      rd(3'h5); chk(q, 32'h8);
      rd(3'h0); chk(q[7:4], 4'h2);
      for (k = 0; k < 8; k++) begin
        rd(3'h7); chk(q[15:0], w[k]);
      end
    end
    wr(3'h1, 32'h4); wr(3'h1, 32'h2); rd(3'h0); chk(q[7:4], 4'h2);
    $display("test arrays done");
    stop_test();
  end
endmodule
bind talk_mode_responder talk_sva sva_u (.*);
